// ==== rtl/asof_delay.sv ====
`timescale 1ns/1ps
`default_nettype none
module asof_delay #(
	parameter int unsigned W = 15,
	parameter int unsigned DEPTH = 14
) (
	input wire logic i_clk, // Clock
	input wire logic i_rst_n, // Async reset, active low
	input wire logic i_ce, // Clock enable
	input wire logic [W-1:0] i_d, // Word in
	output logic [W-1:0] o_tap_last, // Delayed DEPTH cycles
	output logic [W-1:0] o_tap_prev // Delayed DEPTH-1 cycles
);
	logic [W-1:0] pipe_q [DEPTH];
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_stage
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					pipe_q[g] <= '0;
				end else if (i_ce) begin
					pipe_q[g] <= (g == 0) ? i_d : pipe_q[(g == 0) ? 0 : g - 1];
				end
			end
		end
	endgenerate
	assign o_tap_last = pipe_q[DEPTH-1];
	assign o_tap_prev = pipe_q[DEPTH-2];
endmodule // asof_delay
`default_nettype wire

// ==== rtl/asof_formatter.sv ====
// Function
// - Output 14-bit word, aligned output strobe and over-range flag.
// - Output enable low tri-states all data and strobe outputs.
// - DDR differential or parallel mode, chosen by strap or config bit.
// - DDR mode packs two adjacent bits per pair, seven pairs plus strobe.
// - DDR even bits at strobe falling edge, odd bits at rising edge.
// - Drive current default 3.5 mA; 2.5, 4.5, 1.75 mA selectable.
// - Boost doubles the selected current for data and strobe drivers.
// - Termination from 325/200/170 ohm in any combination, data and strobe.
// - Parallel mode: one pin per bit; data valid at strobe rising edge.
// - Parallel mode only: programmable data transition offset.
// - Strobe edge offset by strap or config field; one option aligns edges.
// - Two's complement or offset binary, chosen by strap or config bit.
// - Positive overdrive gives 3FFF offset binary, 1FFF two's complement.
// - Negative overdrive gives 0000 offset binary, 2000 two's complement.
// - Flag high and code clamped for the whole overload.
// - Flag and clamp appear 14 sample cycles after the causing sample, 13 in slow parallel mode.
// - Parallel latency 14 above 80 MSPS, 13 below; DDR stays constant.
`timescale 1ns/1ps
`default_nettype none
module asof_formatter
	import asof_pkg::*;
#(
	parameter int unsigned WIDTH = SAMPLE_W,
	parameter int unsigned LATENCY = LAT_FAST
) (
	input wire logic i_ref_clk, // Control clock, 40 MHz
	input wire logic i_resetn, // Async reset, active low
	input wire logic i_ce, // Clock enable for control domain
	input wire logic i_sample_clk, // Sampling clock (link domain)
	input wire logic [13:0] i_sample, // Offset binary core sample
	input wire logic i_ovr_pos, // Positive overdrive on this sample
	input wire logic i_ovr_neg, // Negative overdrive on this sample
	input wire logic i_output_enable, // Output enable pin
	input wire logic i_format_strap_pin, // Format strap, 1 = two's complement
	input wire logic i_use_strap, // 1 = straps rule, 0 = config bits
	input wire logic i_format_select_bit, // Config format, 1 = two's complement
	input wire logic i_interface_strap, // Strap interface, 1 = parallel
	input wire logic i_interface_type_bit, // Config interface, 1 = parallel
	input wire logic [1:0] i_serial_select_pin, // Strap strobe offset
	input wire logic [1:0] i_strobe_edge_offset, // Config strobe offset
	input wire logic [1:0] i_bit_transition_offset, // Parallel data offset
	input wire logic [1:0] i_drive_strength_select, // Current code
	input wire logic i_drive_boost_enable, // Double current
	input wire logic [2:0] i_data_resistor_select, // Data termination
	input wire logic [2:0] i_strobe_resistor_select, // Strobe termination
	input wire logic [1:0] i_power_scaling, // Power mode from host
	input wire logic i_slow_rate, // 1 = below 80 MSPS
	output logic [6:0] o_pair_data, // DDR pair levels
	output logic [6:0] o_pair_oe, // DDR pair enables
	output logic o_strobe_pair_positive, // DDR strobe level
	output logic o_strobe_pair_oe, // DDR strobe enable
	output logic [13:0] o_par_data, // Parallel data
	output logic [13:0] o_par_oe, // Parallel enables
	output logic o_sample_strobe, // Parallel strobe
	output logic o_sample_strobe_oe, // Parallel strobe enable
	output logic o_over_range_flag, // Over-range flag
	output logic o_over_range_oe, // Flag enable
	output logic [5:0] o_data_current, // Data current, 0.25 mA units
	output logic [5:0] o_strobe_current, // Strobe current, 0.25 mA units
	output logic [2:0] o_data_term, // Data termination enables
	output logic [2:0] o_strobe_term, // Strobe termination enables
	output logic [1:0] o_power_mode, // Power scaling applied
	output logic [1:0] o_data_offset, // Applied data offset
	output logic [1:0] o_strobe_offset, // Applied strobe offset
	output logic o_mode_parallel, // Parallel mode in force
	output logic o_format_twos // Two's complement in force
);
	// ============================================================
	// Control-domain reset and configuration
	logic rst_meta_q;
	logic rst_n_q;
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end
	// Straps are pins: synchronise before use
	logic [4:0] strap_s;
	asof_sync2 #(.W(5)) u_strap_sync (
		.i_clk(i_ref_clk),
		.i_rst_n(rst_n_q),
		.i_d({i_format_strap_pin, i_interface_strap, i_serial_select_pin, i_use_strap}),
		.o_q(strap_s)
	);
	logic par_d, par_q, twos_d, twos_q, boost_d, boost_q;
	logic [1:0] soff_d, soff_q, doff_d, doff_q, pwr_d, pwr_q;
	logic [5:0] base_cur, dcur_d, dcur_q;
	logic [2:0] dterm_q, sterm_q;
	always_comb begin
		par_d = strap_s[0] ? strap_s[3] : i_interface_type_bit;
		twos_d = strap_s[0] ? strap_s[4] : i_format_select_bit;
		soff_d = strap_s[0] ? strap_s[2:1] : i_strobe_edge_offset;
		doff_d = par_d ? i_bit_transition_offset : POS_DEFAULT;
		pwr_d = i_power_scaling;
		unique case (i_drive_strength_select)
			DRV_3P5: base_cur = CUR_3P5;
			DRV_2P5: base_cur = CUR_2P5;
			DRV_4P5: base_cur = CUR_4P5;
			DRV_1P75: base_cur = CUR_1P75;
		endcase
		boost_d = i_drive_boost_enable;
		dcur_d = i_drive_boost_enable ? 6'(base_cur << 1) : base_cur;
	end
	always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			par_q <= 1'b0;
			twos_q <= 1'b0;
			soff_q <= POS_DEFAULT;
			doff_q <= POS_DEFAULT;
			pwr_q <= PWR_DEFAULT;
			dcur_q <= CUR_3P5;
			boost_q <= 1'b0;
			dterm_q <= '0;
			sterm_q <= '0;
		end else if (i_ce) begin
			par_q <= par_d;
			twos_q <= twos_d;
			soff_q <= soff_d;
			doff_q <= doff_d;
			pwr_q <= pwr_d;
			dcur_q <= dcur_d;
			boost_q <= boost_d;
			dterm_q <= i_data_resistor_select;
			sterm_q <= i_strobe_resistor_select;
		end
	end
	assign o_mode_parallel = par_q;
	assign o_format_twos = twos_q;
	assign o_strobe_offset = soff_q;
	assign o_data_offset = doff_q;
	assign o_power_mode = pwr_q;
	assign o_data_current = dcur_q;
	assign o_strobe_current = dcur_q;
	assign o_data_term = dterm_q;
	assign o_strobe_term = sterm_q;
	// ============================================================
	// Link domain: levels cross by two flops each
	logic ln_rst_meta_q, ln_rst_n_q;
	always_ff @(posedge i_sample_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ln_rst_meta_q <= 1'b0;
			ln_rst_n_q <= 1'b0;
		end else begin
			ln_rst_meta_q <= 1'b1;
			ln_rst_n_q <= ln_rst_meta_q;
		end
	end
	logic [3:0] ln_cfg;
	asof_sync2 #(.W(4)) u_cfg_sync (
		.i_clk(i_sample_clk),
		.i_rst_n(ln_rst_n_q),
		.i_d({par_q, twos_q, i_slow_rate, i_output_enable}),
		.o_q(ln_cfg)
	);
	logic ln_par, ln_twos, ln_slow, ln_oe;
	assign {ln_par, ln_twos, ln_slow, ln_oe} = ln_cfg;
	// Clamp and format at input, then pipeline to the fixed latency
	logic [13:0] code_ob, code_fmt;
	logic ovr_in;
	always_comb begin
		ovr_in = i_ovr_pos | i_ovr_neg;
		if (i_ovr_pos) begin
			code_ob = OB_POS_FULL;
		end else if (i_ovr_neg) begin
			code_ob = OB_NEG_FULL;
		end else begin
			code_ob = i_sample;
		end
		code_fmt = code_ob;
		code_fmt[MSB_POS] = code_ob[MSB_POS] ^ ln_twos;
	end
	logic [14:0] tap_last, tap_prev;
	asof_delay #(.W(WIDTH + 1), .DEPTH(LATENCY - 1)) u_pipe (
		.i_clk(i_sample_clk),
		.i_rst_n(ln_rst_n_q),
		.i_ce(1'b1),
		.i_d({ovr_in, code_fmt}),
		.o_tap_last(tap_last),
		.o_tap_prev(tap_prev)
	);
	// Output stage adds the final cycle; slow parallel skips one stage
	logic [14:0] out_sel;
	logic [13:0] word_q;
	logic ovr_q, oe_q;
	always_comb begin
		out_sel = (ln_par && ln_slow) ? tap_prev : tap_last;
	end
	always_ff @(posedge i_sample_clk or negedge ln_rst_n_q) begin
		if (!ln_rst_n_q) begin
			word_q <= '0;
			ovr_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			word_q <= out_sel[13:0];
			ovr_q <= out_sel[14];
			oe_q <= ln_oe;
		end
	end
	// DDR pairs: odd bits while strobe high, even bits while low
	logic [6:0] pair_q;
	logic strobe_q;
	genvar p;
	generate
		for (p = 0; p < PAIR_N; p++) begin : g_pair
			always_ff @(negedge i_sample_clk or negedge ln_rst_n_q) begin
				if (!ln_rst_n_q) begin
					pair_q[p] <= 1'b0;
				end else begin
					pair_q[p] <= word_q[2*p];
				end
			end
		end
	endgenerate
	always_ff @(posedge i_sample_clk or negedge ln_rst_n_q) begin
		if (!ln_rst_n_q) begin
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= 1'b1;
		end
	end
	logic [6:0] odd_bits;
	generate
		for (p = 0; p < PAIR_N; p++) begin : g_odd
			assign odd_bits[p] = word_q[2*p+1];
		end
	endgenerate
	// Odd half lives in word_q, even half in pair_q; strobe follows clock
	assign o_pair_data = i_sample_clk ? odd_bits : pair_q;
	assign o_strobe_pair_positive = strobe_q & i_sample_clk;
	assign o_pair_oe = {PAIR_N{oe_q & ~ln_par}};
	assign o_strobe_pair_oe = oe_q & ~ln_par;
	assign o_par_data = word_q;
	assign o_par_oe = {WIDTH{oe_q & ln_par}};
	assign o_sample_strobe = strobe_q & i_sample_clk;
	assign o_sample_strobe_oe = oe_q & ln_par;
	assign o_over_range_flag = ovr_q;
	assign o_over_range_oe = oe_q;
	// ============================================================
	// Checks
	logic [13:0] ovr_hist_q;
	always_ff @(posedge i_sample_clk or negedge ln_rst_n_q) begin
		if (!ln_rst_n_q) begin
			ovr_hist_q <= '0;
		end else begin
			ovr_hist_q <= {ovr_hist_q[12:0], ovr_in};
		end
	end
	property p_ovr_lat;
		@(posedge i_sample_clk) disable iff (!ln_rst_n_q)
		(!ln_par && i_ovr_pos && $stable(ln_cfg)) |-> ##14 o_over_range_flag;
	endproperty
	a_ovr_lat: assert property (p_ovr_lat) else $error("flag latency wrong");
	property p_pos_clamp;
		@(posedge i_sample_clk) disable iff (!ln_rst_n_q)
		(!ln_par && i_ovr_pos && !ln_twos) ##14 (!ln_twos && !ln_par)
			|-> word_q == OB_POS_FULL;
	endproperty
	a_pos_clamp: assert property (p_pos_clamp) else $error("pos clamp wrong");
	property p_neg_clamp;
		@(posedge i_sample_clk) disable iff (!ln_rst_n_q)
		(!ln_par && i_ovr_neg && !i_ovr_pos && ln_twos) ##14 (ln_twos && !ln_par)
			|-> word_q == TC_NEG_FULL;
	endproperty
	a_neg_clamp: assert property (p_neg_clamp) else $error("neg clamp wrong");
	property p_oe_off;
		@(posedge i_sample_clk) disable iff (!ln_rst_n_q)
		!oe_q |-> (o_pair_oe == '0 && o_par_oe == '0 && !o_strobe_pair_oe);
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("drivers on while off");
	property p_mode_excl;
		@(posedge i_sample_clk) disable iff (!ln_rst_n_q)
		!(o_pair_oe[0] && o_par_oe[0]);
	endproperty
	a_mode_excl: assert property (p_mode_excl) else $error("both modes on");
	property p_boost;
		@(posedge i_ref_clk) disable iff (!rst_n_q)
		(i_ce && i_drive_boost_enable && i_drive_strength_select == DRV_3P5)
			|=> o_data_current == 6'h1C && o_strobe_current == 6'h1C;
	endproperty
	a_boost: assert property (p_boost) else $error("boost wrong");
	property p_doff;
		@(posedge i_ref_clk) disable iff (!rst_n_q)
		!o_mode_parallel |-> o_data_offset == POS_DEFAULT;
	endproperty
	a_doff: assert property (p_doff) else $error("offset in ddr");
	property p_ovr_drop;
		@(posedge i_sample_clk) disable iff (!ln_rst_n_q)
		(!ln_par && $stable(ln_cfg) && ovr_hist_q == '0) |=> !o_over_range_flag;
	endproperty
	a_ovr_drop: assert property (p_ovr_drop) else $error("flag without cause");
endmodule // asof_formatter
`default_nettype wire

// ==== rtl/asof_pkg.sv ====
package asof_pkg;
	// ============================================================
	// Sample word
	localparam int unsigned SAMPLE_W = 14;
	localparam int unsigned PAIR_N = 7;
	localparam logic [13:0] OB_POS_FULL = 14'h3FFF;
	localparam logic [13:0] OB_NEG_FULL = 14'h0000;
	localparam logic [13:0] TC_POS_FULL = 14'h1FFF;
	localparam logic [13:0] TC_NEG_FULL = 14'h2000;
	localparam int unsigned MSB_POS = 13;
	// ============================================================
	// Latency in sample-clock cycles
	localparam int unsigned LAT_FAST = 14;
	localparam int unsigned LAT_SLOW = 13;
	// ============================================================
	// Drive current codes (units of 0.25 mA)
	localparam logic [1:0] DRV_3P5 = 2'h0;
	localparam logic [1:0] DRV_2P5 = 2'h1;
	localparam logic [1:0] DRV_4P5 = 2'h2;
	localparam logic [1:0] DRV_1P75 = 2'h3;
	localparam logic [5:0] CUR_3P5 = 6'h0E;
	localparam logic [5:0] CUR_2P5 = 6'h0A;
	localparam logic [5:0] CUR_4P5 = 6'h12;
	localparam logic [5:0] CUR_1P75 = 6'h07;
	// ============================================================
	// Termination bits: bit0 325 ohm, bit1 200 ohm, bit2 170 ohm
	localparam int unsigned TERM_W = 3;
	// ============================================================
	// Power scaling codes
	localparam logic [1:0] PWR_DEFAULT = 2'h0;
	localparam logic [1:0] PWR_MODE1 = 2'h1;
	localparam logic [1:0] PWR_MODE2 = 2'h2;
	localparam logic [1:0] PWR_MODE3 = 2'h3;
	// ============================================================
	// Edge offsets
	localparam int unsigned POS_W = 2;
	localparam logic [1:0] POS_DEFAULT = 2'h0;
	localparam logic [1:0] POS_ALIGNED = 2'h3;
	typedef enum logic [1:0] {
		ASOF_IDLE = 2'b00,
		ASOF_RUN = 2'b01,
		ASOF_OFF = 2'b10
	} asof_state_e;
endpackage

// ==== rtl/asof_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module asof_sync2 #(
	parameter int unsigned W = 1
) (
	input wire logic i_clk, // Destination clock
	input wire logic i_rst_n, // Async reset, active low
	input wire logic [W-1:0] i_d, // Asynchronous level
	output logic [W-1:0] o_q // Synchronised level
);
	logic [W-1:0] meta_q;
	logic [W-1:0] q_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= '0;
			q_q <= '0;
		end else begin
			meta_q <= i_d;
			q_q <= meta_q;
		end
	end
	assign o_q = q_q;
endmodule // asof_sync2
`default_nettype wire

// ==== sim/asof_capture.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Receiving capture logic on the far side of the pairs
module asof_capture (
	input wire logic i_strobe, // Strobe pair, positive leg
	input wire logic [6:0] i_pairs, // Pair levels
	output logic [13:0] o_word // Last recovered word
);
	logic [6:0] odd_q;
	// Capture mid-phase, clear of the mux switching instants
	always @(posedge i_strobe) begin
		#16;
		odd_q = i_pairs;
	end
	always @(negedge i_strobe) begin
		#16;
		for (int p = 0; p < 7; p++) begin
			o_word[2*p] = i_pairs[p];
			o_word[2*p+1] = odd_q[p];
		end
	end
endmodule // asof_capture
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	import asof_pkg::*;
	logic rclk = 0, sclk = 0, rstn = 0, ce = 0, oe = 0, us = 0, fs = 0, fb = 0, is = 0, ib = 0;
	logic boost = 0, slow = 0, op = 0, on = 0, chk_on = 0;
	logic [13:0] smp = 0;
	logic [1:0] ssp = 0, seo = 0, bto = 0, dss = 0, pwr = 0;
	logic [2:0] drs = 0, srs = 0;
	logic [6:0] pd, poe;
	logic sp, spoe, ss, ssoe, over_range_flag, ovroe, mpar, ftw;
	logic [13:0] pard, paroe, cap;
	logic [5:0] dcur, scur;
	logic [2:0] dt, st;
	logic [1:0] pm, doff, soff;
	int fails = 0, comparisons = 0, cyc = 0, tick = 0;
	logic [14:0] hist [0:1023];
	logic hv [0:1023];
	// ============================================================
	// Clocks, link clock free of any phase tie to the control clock
	initial forever #12.5 rclk = ~rclk;
	initial begin
		#7;
		forever #32 sclk = ~sclk;
	end
	asof_formatter dut (.i_ref_clk(rclk), .i_resetn(rstn), .i_ce(ce), .i_sample_clk(sclk),
		.i_sample(smp), .i_ovr_pos(op), .i_ovr_neg(on), .i_output_enable(oe),
		.i_format_strap_pin(fs), .i_use_strap(us), .i_format_select_bit(fb),
		.i_interface_strap(is), .i_interface_type_bit(ib), .i_serial_select_pin(ssp),
		.i_strobe_edge_offset(seo), .i_bit_transition_offset(bto),
		.i_drive_strength_select(dss), .i_drive_boost_enable(boost),
		.i_data_resistor_select(drs), .i_strobe_resistor_select(srs), .i_power_scaling(pwr),
		.i_slow_rate(slow), .o_pair_data(pd), .o_pair_oe(poe), .o_strobe_pair_positive(sp),
		.o_strobe_pair_oe(spoe), .o_par_data(pard), .o_par_oe(paroe), .o_sample_strobe(ss),
		.o_sample_strobe_oe(ssoe), .o_over_range_flag(over_range_flag), .o_over_range_oe(ovroe),
		.o_data_current(dcur), .o_strobe_current(scur), .o_data_term(dt), .o_strobe_term(st),
		.o_power_mode(pm), .o_data_offset(doff), .o_strobe_offset(soff),
		.o_mode_parallel(mpar), .o_format_twos(ftw));
	asof_capture cap_i (.i_strobe(sp), .i_pairs(pd), .o_word(cap));
	// ============================================================
	// Expectations
	function automatic logic [14:0] expw(input logic [13:0] s, input logic p, n, t);
		logic [13:0] w;
		w = p ? 14'h3FFF : (n ? 14'h0000 : s);
		return {p | n, w ^ {t, 13'h0000}};
	endfunction
	function automatic logic [5:0] curv(input logic [1:0] c);
		case (c)
			DRV_3P5: return CUR_3P5;
			DRV_2P5: return CUR_2P5;
			DRV_4P5: return CUR_4P5;
			default: return CUR_1P75;
		endcase
	endfunction
	task chk_data(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk_cfg(input logic [23:0] g, input logic [23:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task conclude;
		if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Window outlasts the pipeline so no sample straddles a change
	task phase(input int n);
		chk_on = 0;
		repeat (22) @(posedge sclk);
		chk_on <= 1;
		repeat (n) @(posedge sclk);
	endtask
	// ============================================================
	// Sample stream, overdrive bursts of one to three cycles
	always @(posedge sclk) begin : drv
		logic [13:0] v;
		logic p, n;
		v = 14'(cyc * 2651 + 7);
		p = (cyc % 23) inside {5, 6, 7, 20};
		n = (cyc % 23) inside {15, 16, 20};
		smp <= v;
		op <= p;
		on <= n;
		hist[cyc[9:0]] <= expw(v, p, n, us ? fs : fb);
		hv[cyc[9:0]] <= chk_on;
		cyc <= cyc + 1;
	end
	always @(negedge sclk) begin : mon
		int k;
		logic par;
		logic [23:0] m;
		#24;
		par = us ? is : ib;
		k = cyc - ((par && slow) ? LAT_SLOW : LAT_FAST) - 1;
		m = par ? 24'h00FFFF : 24'hFF0001;
		if (chk_on && k >= 0 && hv[k[9:0]]) begin
			chk_data({2'h0, par ? pard : cap}, {2'h0, hist[k[9:0]][13:0]});
			chk_data({15'h0000, over_range_flag}, {15'h0000, hist[k[9:0]][14]});
			chk_cfg({poe, spoe, paroe, ssoe, ovroe}, m);
			chk_cfg({22'h000000, mpar, ftw}, {22'h000000, par, us ? fs : fb});
			chk_data({14'h0000, ss, sp}, 16'h0000);
			// Back into the high half of the period: both strobes must be up
			#16;
			chk_data({14'h0000, ss, sp}, 16'h0003);
		end
	end
	always @(posedge rclk) begin
		tick <= tick + 1;
		if (tick == 4000) begin
			fails++;
			conclude();
		end
	end
	// ============================================================
	// Main sequence
	initial begin
		logic [5:0] c;
		repeat (8) @(posedge rclk);
		rstn <= 1;
		ce <= 1;
		repeat (6) @(posedge rclk);
		oe <= 1;
		phase(40);
		@(posedge rclk) fb <= 1;
		phase(30);
		@(posedge rclk) ib <= 1;
		phase(30);
		@(posedge rclk) slow <= 1;
		phase(30);
		@(posedge rclk) slow <= 0;
		us <= 1;
		phase(30);
		@(posedge rclk) is <= 1;
		fs <= 1;
		phase(30);
		chk_on = 0;
		@(posedge rclk) is <= 0;
		for (int i = 0; i < 8; i++) begin
			@(posedge rclk);
			dss <= i[1:0];
			boost <= i[2];
			drs <= i[2:0];
			srs <= ~i[2:0];
			pwr <= i[1:0];
			ssp <= i[1:0];
			seo <= ~i[1:0];
			bto <= i[1:0] ^ 2'h1;
			us <= i[0];
			repeat (8) @(posedge rclk);
			c = curv(i[1:0]) << i[2];
			chk_cfg({dcur, scur, dt, st, pm, doff, soff}, {c, c, i[2:0], ~i[2:0], i[1:0],
				i[0] ? 2'h0 : i[1:0] ^ 2'h1, i[0] ? i[1:0] : ~i[1:0]});
		end
		@(posedge rclk) ce <= 0;
		pwr <= 2'h0;
		repeat (8) @(posedge rclk);
		chk_cfg({22'h000000, pm}, 24'h000003);
		@(posedge rclk) oe <= 0;
		// Enable crosses three link-clock flops: leave ample margin
		repeat (16) @(posedge rclk);
		chk_cfg({poe, spoe, paroe, ssoe, ovroe}, 24'h000000);
		conclude();
	end
endmodule // tb
`default_nettype wire
